/* logic/clk_synth_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
// Contract
// [R01] Capture both straps when rail-good samples low.
// [R02] Capture once; later rail and strap changes ignored.
// [R03] Mid high strap at capture enters test mode.
// [R04] Test mode: low strap gives ref/N, high Hi-Z.
// [R05] Test mode ends only with a power cycle.
// [R06] Straps 00/01/10 give 100/200/133 MHz.
// [R07] Byte 6 bit 5 doubles processor frequencies.
// [R08] Other outputs stay fixed for valid straps.
// [R09] Configuration bytes load defaults at power-up.
// [R10] Configuration bytes enable individual clock buffers.
// [R11] Controller changes registers only at initialization.
// [R12] Accept byte write, byte read, block write, read.
// [R13] Block bytes ascend, MSB first, stop anytime.
// [R14] Respond only to address byte 11010010.
// [R15] Command bit 7 picks byte; low bits offset.
// [R16] Block write: command, count, data, all acknowledged.
// [R17] Block read: restart, slave sends count and data.
// [R18] Byte write: command, one data byte, acknowledged.
// [R19] Byte read: restart, slave returns one byte.
// [R20] Foreign address gets no acknowledge, line released.
module clk_synth_ctrl (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic cpu_rail_good_n_i,
    input wire logic freq_strap_lo_i,
    input wire logic freq_strap_hi_i,
    input wire logic freq_strap_hi_mid_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_line_i,
    output logic serial_data_line_o,
    output logic serial_data_line_oe_o,
    output var clk_synth_pkg::cpu_freq_t cpu_freq_o,
    output logic fixed_clocks_on_o,
    output logic test_ref_div_o,
    output logic outputs_hiz_o,
    output logic [31:0] clock_enable_o,
    output logic strap_captured_o
);
    import clk_synth_pkg::*;

    logic rst_meta_q, rst_n;
    logic [PIN_COUNT-1:0] pin_meta_q, pin_sync_q;
    logic scl_prev_q, sda_prev_q;
    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

    slave_state_t state_q, state_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] cmd_q, cmd_d;
    logic [6:0] idx_q, idx_d;
    logic count_pend_q, count_pend_d;
    logic read_q, read_d;
    logic oe_q, oe_d;
    logic [7:0] cfg_q [CFG_BYTES];
    logic [7:0] cfg_d [CFG_BYTES];
    logic byte_end, idx_ok, dbl;
    logic [7:0] rd_byte;

    cpu_freq_t cpu_q, cpu_d;
    logic fixed_q, fixed_d;
    logic refdiv_q, refdiv_d;
    logic hiz_q, hiz_d;
    logic [31:0] clk_en_q, clk_en_d;

    strap_if st ();

    // Reset is released through two flops so that no flop sees a runt release.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Every pin is asynchronous to the system clock and passes two flops.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 6'h3f;
            pin_sync_q <= 6'h3f;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            pin_meta_q <= {freq_strap_hi_mid_i, freq_strap_hi_i, freq_strap_lo_i,
                           cpu_rail_good_n_i, serial_data_line_i, serial_clock_i};
            pin_sync_q <= pin_meta_q;
            scl_prev_q <= pin_sync_q[PIN_SCL];
            sda_prev_q <= pin_sync_q[PIN_SDA];
        end
    end

    assign scl_s = pin_sync_q[PIN_SCL];
    assign sda_s = pin_sync_q[PIN_SDA];
    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;
    assign start_det = scl_s && scl_prev_q && !sda_s && sda_prev_q;
    assign stop_det = scl_s && scl_prev_q && sda_s && !sda_prev_q;

    strap_latch u_strap (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n),
        .rail_good_n_i(pin_sync_q[PIN_RAIL]),
        .lo_i(pin_sync_q[PIN_LO]),
        .hi_i(pin_sync_q[PIN_HI]),
        .hi_mid_i(pin_sync_q[PIN_MID]),
        .st(st.latch)
    );

    assign byte_end = scl_fall && (bit_q == BITS_PER_BYTE);
    assign idx_ok = idx_q < 7'(CFG_BYTES);

    // Byte zero shows the straps as latched; they cannot be written.
    always_comb begin
        rd_byte = 8'h00;
        if (count_pend_q && !cmd_q[CMD_BYTE_BIT]) begin
            rd_byte = CFG_COUNT; // [R17]
        end else if (idx_ok) begin
            rd_byte = cfg_q[idx_q[IDX_W-1:0]];
            if (idx_q == 7'h00) begin
                rd_byte[1:0] = {st.hi, st.lo};
            end
        end
    end

    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        shift_d = shift_q;
        cmd_d = cmd_q;
        idx_d = idx_q;
        count_pend_d = count_pend_q;
        read_d = read_q;
        oe_d = oe_q;
        cfg_d = cfg_q;
        if ((state_q == ST_ADDR || state_q == ST_CMD || state_q == ST_WDATA) && scl_rise) begin
            shift_d = {shift_q[6:0], sda_s}; // [R13]
            bit_d = bit_q + 4'h1;
        end
        if (start_det) begin
            state_d = ST_ADDR;
            bit_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop_det) begin
            state_d = ST_IDLE;
            oe_d = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_d = ST_IDLE;
                end
                ST_ADDR: begin
                    if (byte_end) begin
                        bit_d = 4'h0;
                        if (shift_q[7:1] == SLAVE_ADDR) begin // [R14]
                            oe_d = 1'b1;
                            read_d = shift_q[0];
                            state_d = ST_ADDR_ACK;
                        end else begin
                            state_d = ST_IGNORE; // [R20]
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (read_q) begin
                            state_d = ST_RDATA; // [R17] [R19]
                            shift_d = rd_byte;
                            oe_d = ~rd_byte[7];
                            if (count_pend_q) begin
                                count_pend_d = 1'b0;
                            end else if (!cmd_q[CMD_BYTE_BIT]) begin
                                idx_d = idx_q + 7'h01;
                            end
                        end else begin
                            state_d = ST_CMD;
                            oe_d = 1'b0;
                        end
                    end
                end
                ST_CMD: begin
                    if (byte_end) begin
                        bit_d = 4'h0;
                        oe_d = 1'b1;
                        cmd_d = shift_q;
                        state_d = ST_CMD_ACK;
                        if (shift_q[CMD_BYTE_BIT]) begin // [R15]
                            idx_d = shift_q[6:0];
                            count_pend_d = 1'b0;
                        end else begin
                            idx_d = 7'h00;
                            count_pend_d = 1'b1;
                        end
                    end
                end
                ST_CMD_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        state_d = ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (byte_end) begin
                        bit_d = 4'h0;
                        oe_d = 1'b1; // [R16] [R18]
                        state_d = ST_WDATA_ACK;
                        if (cmd_q[CMD_BYTE_BIT]) begin
                            if (idx_ok) begin
                                cfg_d[idx_q[IDX_W-1:0]] = shift_q; // [R18] [R10]
                            end
                        end else if (count_pend_q) begin
                            count_pend_d = 1'b0; // [R16]
                        end else begin
                            if (idx_ok) begin
                                cfg_d[idx_q[IDX_W-1:0]] = shift_q; // [R16] [R13]
                            end
                            idx_d = idx_q + 7'h01;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_q == BITS_PER_BYTE) begin
                            bit_d = 4'h0;
                            oe_d = 1'b0;
                            state_d = ST_MACK;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0}; // [R13]
                            oe_d = ~shift_q[6];
                        end
                    end
                end
                ST_MACK: begin
                    // A not-acknowledge ends the read; the controller may stop at any byte.
                    if (scl_rise && sda_s) begin
                        state_d = ST_IGNORE; // [R13]
                    end else if (scl_fall) begin
                        state_d = ST_RDATA;
                        shift_d = rd_byte;
                        oe_d = ~rd_byte[7];
                        if (count_pend_q) begin
                            count_pend_d = 1'b0;
                        end else if (!cmd_q[CMD_BYTE_BIT]) begin
                            idx_d = idx_q + 7'h01;
                        end
                    end
                end
                ST_IGNORE: begin
                    oe_d = 1'b0; // [R20]
                end
                default: begin
                    state_d = ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin // [R12]
        if (!rst_n) begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            cmd_q <= 8'h00;
            idx_q <= 7'h00;
            count_pend_q <= 1'b0;
            read_q <= 1'b0;
            oe_q <= 1'b0;
            for (int i = 0; i < CFG_BYTES; i++) begin
                cfg_q[i] <= CFG_DEFAULT[i]; // [R09]
            end
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            cmd_q <= cmd_d;
            idx_q <= idx_d;
            count_pend_q <= count_pend_d;
            read_q <= read_d;
            oe_q <= oe_d;
            cfg_q <= cfg_d;
        end
    end

    assign dbl = cfg_q[DOUBLE_BYTE][DOUBLE_BIT];

    // The strap inputs are synchronised and the outputs registered, so the test-mode outputs follow the low strap three clocks late.
    always_comb begin
        cpu_d = CPU_OFF;
        if (st.captured && !st.test_mode) begin
            case ({st.lo, st.hi})
                2'h0: cpu_d = dbl ? CPU_200 : CPU_100; // [R06] [R07]
                2'h1: cpu_d = dbl ? CPU_400 : CPU_200; // [R06] [R07]
                2'h2: cpu_d = dbl ? CPU_266 : CPU_133; // [R06] [R07]
                default: cpu_d = CPU_OFF;
            endcase
        end
        fixed_d = st.captured && !st.test_mode && !(st.lo && st.hi); // [R08]
        refdiv_d = st.test_mode && !pin_sync_q[PIN_LO]; // [R04]
        hiz_d = st.test_mode && pin_sync_q[PIN_LO]; // [R04]
        clk_en_d = {cfg_q[CLK_EN_FIRST+3], cfg_q[CLK_EN_FIRST+2],
                    cfg_q[CLK_EN_FIRST+1], cfg_q[CLK_EN_FIRST]}; // [R10]
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            cpu_q <= CPU_OFF;
            fixed_q <= 1'b0;
            refdiv_q <= 1'b0;
            hiz_q <= 1'b0;
            clk_en_q <= 32'h00000000;
        end else begin
            cpu_q <= cpu_d;
            fixed_q <= fixed_d;
            refdiv_q <= refdiv_d;
            hiz_q <= hiz_d;
            clk_en_q <= clk_en_d;
        end
    end

    assign serial_data_line_o = 1'b0;
    assign serial_data_line_oe_o = oe_q;
    assign cpu_freq_o = cpu_q;
    assign fixed_clocks_on_o = fixed_q;
    assign test_ref_div_o = refdiv_q;
    assign outputs_hiz_o = hiz_q;
    assign clock_enable_o = clk_en_q;
    assign strap_captured_o = st.captured;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    sequence s_own_addr;
        state_q == ST_ADDR && byte_end && shift_q[7:1] == SLAVE_ADDR;
    endsequence
    sequence s_foreign_addr;
        state_q == ST_ADDR && byte_end && shift_q[7:1] != SLAVE_ADDR;
    endsequence
    sequence s_block_read_addr;
        state_q == ST_ADDR_ACK && read_q && count_pend_q && !cmd_q[7] && scl_fall;
    endsequence

    property p_addr_ack;
        s_own_addr |=> serial_data_line_oe_o && state_q == ST_ADDR_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("Own address not acknowledged."); // [R14]

    property p_foreign;
        s_foreign_addr |=> (!serial_data_line_oe_o) [*8];
    endproperty
    a_foreign: assert property (p_foreign) else $error("Foreign address drove the line."); // [R20]

    property p_block_count;
        s_block_read_addr |=> shift_q == CFG_COUNT && serial_data_line_oe_o == ~CFG_COUNT[7];
    endproperty
    a_block_count: assert property (p_block_count) else $error("Block read count missing."); // [R17]

    property p_block_step;
        state_q == ST_WDATA && byte_end && !cmd_q[7] && !count_pend_q
            |=> idx_q == $past(idx_q) + 7'h01 && state_q == ST_WDATA_ACK;
    endproperty
    a_block_step: assert property (p_block_step) else $error("Block index did not advance."); // [R13]

    property p_byte_write;
        state_q == ST_WDATA && byte_end && cmd_q[7] && idx_q == 7'h06
            |=> cfg_q[6] == $past(shift_q) ##1 dbl == $past(shift_q[5], 2);
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("Byte write not stored."); // [R18]

    property p_cpu_200;
        st.captured && !st.test_mode && !st.lo && st.hi && !dbl |=> cpu_freq_o == CPU_200;
    endproperty
    a_cpu_200: assert property (p_cpu_200) else $error("Strap 01 not 200 MHz."); // [R06]

    property p_cpu_266;
        st.captured && !st.test_mode && st.lo && !st.hi && dbl |=> cpu_freq_o == CPU_266;
    endproperty
    a_cpu_266: assert property (p_cpu_266) else $error("Doubled strap 10 not 266 MHz."); // [R07]

    property p_test_out;
        st.test_mode && !pin_sync_q[PIN_LO]
            |=> test_ref_div_o && !outputs_hiz_o && cpu_freq_o == CPU_OFF;
    endproperty
    a_test_out: assert property (p_test_out) else $error("Test mode outputs wrong."); // [R04]
endmodule // clk_synth_ctrl
`default_nettype wire

/* logic/clk_synth_pkg.sv */
`default_nettype none
package clk_synth_pkg;
    localparam int CFG_BYTES = 8;
    localparam int IDX_W = 3;
    localparam logic [6:0] SLAVE_ADDR = 7'h69;
    localparam logic [7:0] CFG_COUNT = 8'h08;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int DOUBLE_BYTE = 6;
    localparam int DOUBLE_BIT = 5;
    localparam int CMD_BYTE_BIT = 7;
    localparam int CLK_EN_FIRST = 2;
    localparam logic [7:0] CFG_DEFAULT [CFG_BYTES] = '{
        8'h40, 8'h70, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00
    };
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_RAIL = 2;
    localparam int PIN_LO = 3;
    localparam int PIN_HI = 4;
    localparam int PIN_MID = 5;
    localparam int PIN_COUNT = 6;

    typedef enum logic [2:0] {
        CPU_OFF = 3'b000,
        CPU_100 = 3'b001,
        CPU_133 = 3'b010,
        CPU_200 = 3'b011,
        CPU_266 = 3'b100,
        CPU_400 = 3'b101
    } cpu_freq_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_CMD = 4'b0011,
        ST_CMD_ACK = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_MACK = 4'b1000,
        ST_IGNORE = 4'b1001
    } slave_state_t;
endpackage
`default_nettype wire

/* logic/strap_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface strap_if;
    logic captured;
    logic test_mode;
    logic lo;
    logic hi;
    modport latch (output captured, output test_mode, output lo, output hi);
    modport user (input captured, input test_mode, input lo, input hi);
endinterface
`default_nettype wire

/* logic/strap_latch.sv */
`timescale 1ns/1ns
`default_nettype none
module strap_latch (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rail_good_n_i,
    input wire logic lo_i,
    input wire logic hi_i,
    input wire logic hi_mid_i,
    strap_if.latch st
);
    logic captured_q, captured_d;
    logic test_q, test_d;
    logic lo_q, lo_d;
    logic hi_q, hi_d;

    // Only the first low sample counts; afterwards every strap edge is ignored.
    always_comb begin
        captured_d = captured_q;
        test_d = test_q;
        lo_d = lo_q;
        hi_d = hi_q;
        if (!captured_q && !rail_good_n_i) begin // [R01] [R02]
            captured_d = 1'b1;
            lo_d = lo_i;
            hi_d = hi_i;
            test_d = hi_mid_i; // [R03]
        end
    end

    // Test mode is left only by reset, which stands for a power cycle.
    always_ff @(posedge clk_i or negedge rst_n_i) begin // [R05]
        if (!rst_n_i) begin
            captured_q <= 1'b0;
            test_q <= 1'b0;
            lo_q <= 1'b0;
            hi_q <= 1'b0;
        end else begin
            captured_q <= captured_d;
            test_q <= test_d;
            lo_q <= lo_d;
            hi_q <= hi_d;
        end
    end

    assign st.captured = captured_q;
    assign st.test_mode = test_q;
    assign st.lo = lo_q;
    assign st.hi = hi_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_capture_low;
        !captured_q && !rail_good_n_i |=> captured_q && lo_q == $past(lo_i) && hi_q == $past(hi_i);
    endproperty
    a_capture_low: assert property (p_capture_low) else $error("Straps not captured on low."); // [R01]

    property p_one_shot;
        captured_q |=> captured_q && $stable(lo_q) && $stable(hi_q) && $stable(test_q);
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("Captured straps changed."); // [R02]

    property p_test_entry;
        !captured_q && !rail_good_n_i && hi_mid_i |=> test_q;
    endproperty
    a_test_entry: assert property (p_test_entry) else $error("Mid strap missed test mode."); // [R03]

    property p_test_sticky;
        test_q |=> test_q ##1 test_q;
    endproperty
    a_test_sticky: assert property (p_test_sticky) else $error("Test mode left without reset."); // [R05]
endmodule // strap_latch
`default_nettype wire

/* verification/smbus_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Open-drain controller: pull_o high pulls the data line low. Phases last eight system clocks.
module smbus_host_model (
    input wire logic clk_i,
    input wire logic line_i,
    output logic scl_o,
    output logic pull_o
);
    localparam int HALF = 8;
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Also serves as the repeated start, so the clock is parked low first.
    task automatic start();
        if (scl_o) begin
            scl_o = 1'b0;
        end
        tick(HALF);
        pull_o = 1'b0;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        pull_o = 1'b1;
        tick(HALF);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        pull_o = 1'b1;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        pull_o = 1'b0;
        tick(HALF);
    endtask
    // Data changes only while the clock is low; the line is sampled just before the fall.
    task automatic put_bit(input logic b, output logic seen);
        pull_o = ~b;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        seen = line_i;
        scl_o = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i], s);
        end
        put_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            v[i] = s;
        end
        put_bit(last, s);
    endtask
endmodule // smbus_host_model
`default_nettype wire

/* verification/clock_freq_select_and_smbus_slave_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module clock_freq_select_and_smbus_slave_bench;
    import clk_synth_pkg::*;
    logic clk_sys_i, resetn_i, rail, lo, hi, mid, scl, pull, oe, line, el, eh, cap, tref, hiz, fix;
    logic sdo;
    cpu_freq_t cpu;
    logic [31:0] cen, seed;
    logic [7:0] v, r, blk [4];
    int failures, n_checks;
    assign line = ~pull & (oe ? sdo : 1'b1);
    clk_synth_ctrl clk_synth_ctrl_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .cpu_rail_good_n_i(rail), .freq_strap_lo_i(lo), .freq_strap_hi_i(hi),
        .freq_strap_hi_mid_i(mid), .serial_clock_i(scl), .serial_data_line_i(line),
        .serial_data_line_o(sdo), .serial_data_line_oe_o(oe), .cpu_freq_o(cpu),
        .fixed_clocks_on_o(fix), .test_ref_div_o(tref), .outputs_hiz_o(hiz),
        .clock_enable_o(cen), .strap_captured_o(cap));
    smbus_host_model host_i (.clk_i(clk_sys_i), .line_i(line), .scl_o(scl), .pull_o(pull));
    always #10 clk_sys_i = ~clk_sys_i;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic cpu_freq_t exp_freq(input logic a, input logic b, input logic dbl);
        case ({a, b})
            2'b00: return dbl ? CPU_200 : CPU_100;
            2'b01: return dbl ? CPU_400 : CPU_200;
            2'b10: return dbl ? CPU_266 : CPU_133;
            default: return CPU_OFF;
        endcase
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic send(input logic [7:0] b, input logic want);
        logic a;
        host_i.put_byte(b, a);
        check({31'h0, a}, {31'h0, want}, "acknowledge");
    endtask
    task automatic power_up(input logic a, input logic b, input logic m);
        int k;
        resetn_i = 1'b0;
        rail = 1'b1;
        {lo, hi, mid} = {a, b, m};
        ticks(16);
        resetn_i = 1'b1;
        ticks(8);
        rail = 1'b0;
        k = 0;
        while (cap !== 1'b1 && k < 20) begin
            ticks(1);
            k++;
        end
        if (cap !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t capture never seen", $time);
            final_report();
        end
        ticks(4);
    endtask
    task automatic byte_rd(input logic [7:0] off, output logic [7:0] b);
        host_i.start();
        send(8'hd2, 1'b1);
        send({1'b1, off[6:0]}, 1'b1);
        host_i.start();
        send(8'hd3, 1'b1);
        host_i.get_byte(1'b1, b);
        host_i.stop();
    endtask
    task automatic byte_wr(input logic [7:0] off, input logic [7:0] b);
        host_i.start();
        send(8'hd2, 1'b1);
        send({1'b1, off[6:0]}, 1'b1);
        send(b, 1'b1);
        host_i.stop();
        ticks(6);
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        failures++;
        $display("[FAIL] %0t run did not finish", $time);
        final_report();
    end
    initial begin
        clk_sys_i = 1'b0;
        seed = 32'h00015995;
        failures = 0;
        n_checks = 0;
        resetn_i = 1'b0;
        {rail, lo, hi, mid} = 4'b1000;
        ticks(16);
        resetn_i = 1'b1;
        ticks(6);
        check(cen, 32'hffffffff, "buffer enable default");
        check({31'h0, cap}, 32'h0, "no capture before rail good");
        r = 8'(rnd() % 3);
        el = (r == 8'h02);
        eh = (r == 8'h01);
        power_up(el, eh, 1'b0);
        check({29'h0, cpu}, {29'h0, exp_freq(el, eh, 1'b0)}, "cpu frequency");
        check({31'h0, fix}, 32'h1, "fixed clocks");
        {rail, lo, hi} = {1'b1, ~el, ~eh};
        ticks(10);
        rail = 1'b0;
        ticks(10);
        check({29'h0, cpu}, {29'h0, exp_freq(el, eh, 1'b0)}, "one shot");
        $display("test strap capture done");
        byte_wr(8'h06, 8'h20);
        check({29'h0, cpu}, {29'h0, exp_freq(el, eh, 1'b1)}, "doubled");
        byte_rd(8'h06, v);
        check({24'h0, v}, 32'h20, "byte read");
        r = 8'(rnd());
        byte_wr(8'h02, r);
        check({24'h0, cen[7:0]}, {24'h0, r}, "buffer enable");
        $display("test byte access done");
        host_i.start();
        send(8'hd2, 1'b1);
        send(8'h00, 1'b1);
        send(8'h04, 1'b1);
        for (int i = 0; i < 4; i++) begin
            blk[i] = 8'(rnd());
            send(blk[i], 1'b1);
        end
        host_i.stop();
        host_i.start();
        send(8'hd2, 1'b1);
        send(8'h00, 1'b1);
        host_i.start();
        send(8'hd3, 1'b1);
        host_i.get_byte(1'b0, v);
        check({24'h0, v}, {24'h0, CFG_COUNT}, "block count");
        for (int i = 0; i < 4; i++) begin
            host_i.get_byte(i == 3, v);
            r = (i == 0) ? {blk[0][7:2], eh, el} : blk[i];
            check({24'h0, v}, {24'h0, r}, "block data");
        end
        host_i.stop();
        ticks(6);
        check({16'h0, cen[15:0]}, {16'h0, blk[3], blk[2]}, "block enables");
        $display("test block access done");
        host_i.start();
        send(8'hd4, 1'b0);
        send(8'h86, 1'b0);
        host_i.stop();
        $display("test foreign address done");
        for (int s = 0; s < 4; s++) begin
            power_up(s[1], s[0], 1'b0);
            check({29'h0, cpu}, {29'h0, exp_freq(s[1], s[0], 1'b0)}, "strap corner");
            check({31'h0, fix}, {31'h0, s != 3}, "strap corner fixed");
            byte_wr(8'h06, 8'h20);
            check({29'h0, cpu}, {29'h0, exp_freq(s[1], s[0], 1'b1)}, "corner doubled");
        end
        byte_rd(8'h0a, v);
        check({24'h0, v}, 32'h0, "offset beyond map");
        $display("test strap corners done");
        power_up(1'b0, 1'b0, 1'b1);
        check({30'h0, tref, hiz}, 32'h2, "test mode divided");
        lo = 1'b1;
        ticks(8);
        check({30'h0, tref, hiz}, 32'h1, "test mode hi-z");
        {mid, hi} = 2'b01;
        ticks(8);
        check({30'h0, tref, hiz}, 32'h1, "test mode kept");
        power_up(1'b0, 1'b0, 1'b0);
        check({30'h0, tref, hiz}, 32'h0, "test mode left");
        check({29'h0, cpu}, {29'h0, CPU_100}, "normal again");
        $display("test clock mode done");
        final_report();
    end
endmodule // clock_freq_select_and_smbus_slave_bench
`default_nettype wire
